/* File: design/pat_pkg.sv */
package pat_pkg;
  // address widths
  localparam int unsigned PAT_LA_W = 16;
  localparam int unsigned PAT_GA_W = 23;
  localparam int unsigned PAT_PG_W = 8;
  localparam int unsigned PAT_GP_W = 7;
  // local windows
  localparam logic [15:0] PAT_REG_HI = 16'h07FF;
  localparam logic [15:0] PAT_EEP_LO = 16'h0800;
  localparam logic [15:0] PAT_EEP_HI = 16'h0BFF;
  localparam logic [15:0] PAT_RAM_LO = 16'h1000;
  localparam logic [15:0] PAT_RAM_HI = 16'h1FFF;
  localparam logic [15:0] PAT_PROG_LO = 16'h8000;
  localparam logic [15:0] PAT_PROG_HI = 16'hBFFF;
  // fixed upper global bits of each region
  localparam logic [6:0] PAT_REG_GP = 7'h00;
  localparam logic [6:0] PAT_UNPAGED_GP = 7'h7F;
  localparam logic [6:0] PAT_COP_GP = 7'h78;
  localparam logic [2:0] PAT_RAM_TOP = 3'h0;
  localparam logic [4:0] PAT_EEP_TOP = 5'h04;
  localparam logic [0:0] PAT_PROG_TOP = 1'h1;
  // apb register offsets
  localparam logic [7:0] PAT_OFF_PROG = 8'h00;
  localparam logic [7:0] PAT_OFF_RAM = 8'h04;
  localparam logic [7:0] PAT_OFF_EEP = 8'h08;
  localparam logic [7:0] PAT_OFF_CGP = 8'h0C;
  localparam logic [7:0] PAT_OFF_DGP = 8'h10;
  localparam logic [7:0] PAT_OFF_CTRL = 8'h14;
  localparam logic [7:0] PAT_OFF_STAT = 8'h18;
  localparam logic [7:0] PAT_OFF_MASK = 8'h1C;
  // control fields
  localparam int unsigned PAT_CTRL_SC = 0;
  localparam int unsigned PAT_CTRL_FP = 8;
  // status bits
  localparam int unsigned PAT_ST_W = 3;
  localparam int unsigned PAT_ST_UNIMP = 0;
  localparam int unsigned PAT_ST_DBGWR = 1;
  localparam int unsigned PAT_ST_EXT = 2;
  // debug register select codes
  localparam logic [2:0] PAT_DSEL_PROG = 3'h0;
  localparam logic [2:0] PAT_DSEL_RAM = 3'h1;
  localparam logic [2:0] PAT_DSEL_EEP = 3'h2;
  localparam logic [2:0] PAT_DSEL_DGP = 3'h3;
  // reset values
  localparam logic [7:0] PAT_RST_PROG = 8'hFE;
  localparam logic [7:0] PAT_RST_RAM = 8'hFD;
  localparam logic [7:0] PAT_RST_EEP = 8'hFE;
  localparam logic [6:0] PAT_RST_GP = 7'h00;
  localparam logic [7:0] PAT_RST_FP = 8'hF8;
  localparam logic PAT_RST_SC = 1'b1;
endpackage

/* File: design/pat_xlate.sv */
`timescale 1ns/1ps
`default_nettype none
module pat_xlate #(
  parameter int unsigned LA_W = 16,
  parameter int unsigned GA_W = 23,
  parameter int unsigned PG_W = 8,
  parameter int unsigned GP_W = 7
) (
  input wire logic [LA_W-1:0] local_addr,
  input wire logic use_global,
  input wire logic [GP_W-1:0] global_page,
  input wire logic [PG_W-1:0] prog_page,
  input wire logic [PG_W-1:0] ram_page,
  input wire logic [PG_W-1:0] eep_page,
  input wire logic [PG_W-1:0] first_page,
  output logic [GA_W-1:0] global_addr,
  output logic is_external
);
  // window select and address forming
  always_comb begin
    if (use_global) begin
      global_addr = {global_page, local_addr};
    end else if (local_addr >= pat_pkg::PAT_PROG_LO && local_addr <= pat_pkg::PAT_PROG_HI) begin
      global_addr = {pat_pkg::PAT_PROG_TOP, prog_page, local_addr[13:0]};
    end else if (local_addr >= pat_pkg::PAT_RAM_LO && local_addr <= pat_pkg::PAT_RAM_HI) begin
      global_addr = {pat_pkg::PAT_RAM_TOP, ram_page, local_addr[11:0]};
    end else if (local_addr >= pat_pkg::PAT_EEP_LO && local_addr <= pat_pkg::PAT_EEP_HI) begin
      global_addr = {pat_pkg::PAT_EEP_TOP, eep_page, local_addr[9:0]};
    end else if (local_addr <= pat_pkg::PAT_REG_HI) begin
      global_addr = {pat_pkg::PAT_REG_GP, local_addr};
    end else begin
      global_addr = {pat_pkg::PAT_UNPAGED_GP, local_addr};
    end
  end

  // program space below the first on-chip page goes off-chip
  always_comb begin
    is_external = global_addr[GA_W-1] && (global_addr[GA_W-2:GA_W-1-PG_W] < first_page);
  end
endmodule
`default_nettype wire

/* File: design/pat_mmc.sv */
// Notes on behaviour
// - an eight-bit ram page maps 4 Kbyte pages into local $1000-$1FFF.
// - an eight-bit eeprom page maps 1 Kbyte pages into the window from $0800.
// - the debug unit's paged accesses use the same three page registers, which it can read and write.
// - debug paged accesses translate exactly as core paged accesses do.
// - the core global page is seven bits and reaches the 8 Mbyte space with 23 bits.
// - the core global page applies only during a global-addressing instruction.
// - a core global address is the page as bits 22:16 above the local address.
// - the debug global page is seven bits and reaches the 8 Mbyte space with 23 bits.
// - the debug global page applies only to firmware global load/store and hardware read/write commands.
// - debug global uses debug local address for hardware and core local address for firmware commands.
// - the 64 Kbyte local map is addressed by 16 bits and its contents depend on the page values.
// - a paged program access goes internal or external depending on the on-chip memory size.
// - in single-chip mode a core access to an unimplemented address raises a system reset.
// - core, debug unit and coprocessor each have a separate map, the coprocessor its own 64 Kbyte one.
// - translation runs in run and wait mode and is inactive in stop mode.
// - an eight-bit program page maps 16 Kbyte pages into $8000-$BFFF, with $C000-$FFFF unpaged.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pat_mmc #(
  parameter int unsigned LA_W = pat_pkg::PAT_LA_W,
  parameter int unsigned GA_W = pat_pkg::PAT_GA_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic core_req,
  input wire logic [LA_W-1:0] core_addr,
  input wire logic core_global_instr,
  output logic core_gvalid,
  output logic [GA_W-1:0] core_gaddr,
  output logic core_external,
  input wire logic dbg_req,
  input wire logic [LA_W-1:0] dbg_addr,
  input wire logic dbg_hw_cmd,
  input wire logic dbg_fw_global,
  output logic dbg_gvalid,
  output logic [GA_W-1:0] dbg_gaddr,
  output logic dbg_external,
  input wire logic dbg_reg_wr,
  input wire logic [2:0] dbg_reg_sel,
  input wire logic [7:0] dbg_reg_wdata,
  output logic [7:0] dbg_reg_rdata,
  input wire logic cop_req,
  input wire logic [LA_W-1:0] cop_addr,
  output logic cop_gvalid,
  output logic [GA_W-1:0] cop_gaddr,
  output logic sys_reset_req,
  output logic irq
);
  typedef struct packed {
    logic [7:0] prog;
    logic [7:0] ram;
    logic [7:0] eep;
    logic [6:0] cgp;
    logic [6:0] dgp;
    logic single_chip;
    logic [7:0] first_page;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_gv;
    logic [22:0] core_ga;
    logic core_ext;
    logic dbg_gv;
    logic [22:0] dbg_ga;
    logic dbg_ext;
    logic cop_gv;
    logic [22:0] cop_ga;
    logic sys_rst;
    logic irq;
    logic [7:0] dbg_rd;
  } pat_state_t;

  pat_state_t s_reg;
  pat_state_t s_next;
  logic [22:0] core_ga_c;
  logic core_ext_c;
  logic [22:0] dbg_ga_c;
  logic dbg_ext_c;
  logic [6:0] core_page;
  logic core_use_g;
  logic setup;
  logic access;
  logic mapped;
  logic [2:0] st_set;
  logic [2:0] st_clr;

  // firmware global commands run on the core but take the debug page
  assign core_page = dbg_fw_global ? s_reg.dgp : s_reg.cgp;
  assign core_use_g = core_global_instr | dbg_fw_global;

  // core side translator
  pat_xlate #(.LA_W(LA_W), .GA_W(GA_W), .PG_W(8), .GP_W(7)) u_core_xl (
    .local_addr(core_addr),
    .use_global(core_use_g),
    .global_page(core_page),
    .prog_page(s_reg.prog),
    .ram_page(s_reg.ram),
    .eep_page(s_reg.eep),
    .first_page(s_reg.first_page),
    .global_addr(core_ga_c),
    .is_external(core_ext_c)
  );

  // debug side translator, same paging scheme as the core
  pat_xlate #(.LA_W(LA_W), .GA_W(GA_W), .PG_W(8), .GP_W(7)) u_dbg_xl (
    .local_addr(dbg_addr),
    .use_global(dbg_hw_cmd),
    .global_page(s_reg.dgp),
    .prog_page(s_reg.prog),
    .ram_page(s_reg.ram),
    .eep_page(s_reg.eep),
    .first_page(s_reg.first_page),
    .global_addr(dbg_ga_c),
    .is_external(dbg_ext_c)
  );

  // apb phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable & s_reg.pready;
  assign mapped = (paddr[31:8] == 24'h000000) && (paddr[7:0] <= pat_pkg::PAT_OFF_MASK) && (paddr[1:0] == 2'h0);

  // next state
  always_comb begin
    s_next = s_reg;
    st_set = 3'h0;
    st_clr = 3'h0;
    // apb answer prepared in setup, shown in the first access cycle
    s_next.pready = setup & ~s_reg.pready;
    if (setup) begin
      s_next.pslverr = ~mapped;
      s_next.prdata = 32'h00000000;
      if (mapped) begin
        case (paddr[7:0])
          pat_pkg::PAT_OFF_PROG: s_next.prdata = {24'h000000, s_reg.prog};
          pat_pkg::PAT_OFF_RAM: s_next.prdata = {24'h000000, s_reg.ram};
          pat_pkg::PAT_OFF_EEP: s_next.prdata = {24'h000000, s_reg.eep};
          pat_pkg::PAT_OFF_CGP: s_next.prdata = {25'h0000000, s_reg.cgp};
          pat_pkg::PAT_OFF_DGP: s_next.prdata = {25'h0000000, s_reg.dgp};
          pat_pkg::PAT_OFF_CTRL: s_next.prdata = {16'h0000, s_reg.first_page, 7'h00, s_reg.single_chip};
          pat_pkg::PAT_OFF_STAT: s_next.prdata = {29'h00000000, s_reg.status};
          pat_pkg::PAT_OFF_MASK: s_next.prdata = {29'h00000000, s_reg.mask};
          default: s_next.prdata = 32'h00000000;
        endcase
      end
    end
    // register writes at the completing edge
    if (access && pwrite && !s_reg.pslverr) begin
      case (paddr[7:0])
        pat_pkg::PAT_OFF_PROG: s_next.prog = pwdata[7:0];
        pat_pkg::PAT_OFF_RAM: s_next.ram = pwdata[7:0];
        pat_pkg::PAT_OFF_EEP: s_next.eep = pwdata[7:0];
        pat_pkg::PAT_OFF_CGP: s_next.cgp = pwdata[6:0];
        pat_pkg::PAT_OFF_DGP: s_next.dgp = pwdata[6:0];
        pat_pkg::PAT_OFF_CTRL: begin
          s_next.single_chip = pwdata[pat_pkg::PAT_CTRL_SC];
          s_next.first_page = pwdata[pat_pkg::PAT_CTRL_FP +: 8];
        end
        pat_pkg::PAT_OFF_MASK: s_next.mask = pwdata[2:0];
        default: s_next.mask = s_reg.mask;
      endcase
    end
    // a status read clears exactly the bits it returned
    if (access && !pwrite && !s_reg.pslverr && paddr[7:0] == pat_pkg::PAT_OFF_STAT) begin
      st_clr = s_reg.prdata[2:0];
    end
    // debug unit writes page registers, winning over apb
    if (dbg_reg_wr) begin
      st_set[pat_pkg::PAT_ST_DBGWR] = 1'b1;
      case (dbg_reg_sel)
        pat_pkg::PAT_DSEL_PROG: s_next.prog = dbg_reg_wdata;
        pat_pkg::PAT_DSEL_RAM: s_next.ram = dbg_reg_wdata;
        pat_pkg::PAT_DSEL_EEP: s_next.eep = dbg_reg_wdata;
        pat_pkg::PAT_DSEL_DGP: s_next.dgp = dbg_reg_wdata[6:0];
        default: st_set[pat_pkg::PAT_ST_DBGWR] = 1'b0;
      endcase
    end
    // debug read-back of the page registers
    case (dbg_reg_sel)
      pat_pkg::PAT_DSEL_PROG: s_next.dbg_rd = s_reg.prog;
      pat_pkg::PAT_DSEL_RAM: s_next.dbg_rd = s_reg.ram;
      pat_pkg::PAT_DSEL_EEP: s_next.dbg_rd = s_reg.eep;
      pat_pkg::PAT_DSEL_DGP: s_next.dbg_rd = {1'b0, s_reg.dgp};
      default: s_next.dbg_rd = 8'h00;
    endcase
    // translation, frozen while stopped
    s_next.core_gv = 1'b0;
    s_next.dbg_gv = 1'b0;
    s_next.cop_gv = 1'b0;
    s_next.sys_rst = 1'b0;
    if (!stop_mode) begin
      s_next.core_gv = core_req;
      s_next.dbg_gv = dbg_req;
      s_next.cop_gv = cop_req;
      if (core_req) begin
        s_next.core_ga = core_ga_c;
        s_next.core_ext = core_ext_c;
        s_next.sys_rst = s_reg.single_chip & core_ext_c;
        st_set[pat_pkg::PAT_ST_UNIMP] = s_reg.single_chip & core_ext_c;
        st_set[pat_pkg::PAT_ST_EXT] = core_ext_c;
      end
      if (dbg_req) begin
        s_next.dbg_ga = dbg_ga_c;
        s_next.dbg_ext = dbg_ext_c;
        st_set[pat_pkg::PAT_ST_EXT] = st_set[pat_pkg::PAT_ST_EXT] | dbg_ext_c;
      end
      if (cop_req) begin
        s_next.cop_ga = {pat_pkg::PAT_COP_GP, cop_addr};
      end
    end
    // sticky status, set wins over clear
    s_next.status = (s_reg.status & ~st_clr) | st_set;
    s_next.irq = |(s_next.status & s_next.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.prog <= pat_pkg::PAT_RST_PROG;
      s_reg.ram <= pat_pkg::PAT_RST_RAM;
      s_reg.eep <= pat_pkg::PAT_RST_EEP;
      s_reg.cgp <= pat_pkg::PAT_RST_GP;
      s_reg.dgp <= pat_pkg::PAT_RST_GP;
      s_reg.first_page <= pat_pkg::PAT_RST_FP;
      s_reg.single_chip <= pat_pkg::PAT_RST_SC;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign core_gvalid = s_reg.core_gv;
  assign core_gaddr = s_reg.core_ga;
  assign core_external = s_reg.core_ext;
  assign dbg_gvalid = s_reg.dbg_gv;
  assign dbg_gaddr = s_reg.dbg_ga;
  assign dbg_external = s_reg.dbg_ext;
  assign cop_gvalid = s_reg.cop_gv;
  assign cop_gaddr = s_reg.cop_ga;
  assign sys_reset_req = s_reg.sys_rst;
  assign irq = s_reg.irq;
  assign dbg_reg_rdata = s_reg.dbg_rd;

  // checks on translation and control
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic core_paged;
  assign core_paged = core_req && !stop_mode && !core_global_instr && !dbg_fw_global;

  ram_window_a: assert property (
    core_paged && core_addr >= pat_pkg::PAT_RAM_LO && core_addr <= pat_pkg::PAT_RAM_HI
    |=> core_gaddr == {pat_pkg::PAT_RAM_TOP, $past(s_reg.ram), $past(core_addr[11:0])})
    else $error("ram window address wrong");

  eep_window_a: assert property (
    core_paged && core_addr >= pat_pkg::PAT_EEP_LO && core_addr <= pat_pkg::PAT_EEP_HI
    |=> core_gaddr == {pat_pkg::PAT_EEP_TOP, $past(s_reg.eep), $past(core_addr[9:0])})
    else $error("eeprom window address wrong");

  prog_window_a: assert property (
    core_paged && core_addr >= pat_pkg::PAT_PROG_LO && core_addr <= pat_pkg::PAT_PROG_HI
    |=> core_gaddr == {pat_pkg::PAT_PROG_TOP, $past(s_reg.prog), $past(core_addr[13:0])})
    else $error("program window address wrong");

  unpaged_top_a: assert property (
    core_paged && core_addr > pat_pkg::PAT_PROG_HI
    |=> core_gvalid && core_gaddr == {pat_pkg::PAT_UNPAGED_GP, $past(core_addr)})
    else $error("unpaged address moved");

  core_global_a: assert property (
    core_req && !stop_mode && core_global_instr && !dbg_fw_global
    |=> core_gaddr == {$past(s_reg.cgp), $past(core_addr)})
    else $error("core global address wrong");

  fw_global_a: assert property (
    core_req && !stop_mode && dbg_fw_global
    |=> core_gaddr == {$past(s_reg.dgp), $past(core_addr)})
    else $error("firmware global address wrong");

  hw_global_a: assert property (
    dbg_req && !stop_mode && dbg_hw_cmd
    |=> dbg_gvalid && dbg_gaddr == {$past(s_reg.dgp), $past(dbg_addr)})
    else $error("debug hardware global address wrong");

  same_scheme_a: assert property (
    dbg_req && core_paged && !dbg_hw_cmd && dbg_addr == core_addr
    |=> dbg_gaddr == core_gaddr && dbg_external == core_external)
    else $error("debug and core paging differ");

  dbg_write_a: assert property (
    dbg_reg_wr && dbg_reg_sel == pat_pkg::PAT_DSEL_PROG
    ##1 dbg_reg_sel == pat_pkg::PAT_DSEL_PROG |=> dbg_reg_rdata == $past(dbg_reg_wdata, 2))
    else $error("debug page write not seen");

  unimp_reset_a: assert property (
    core_req && !stop_mode && s_reg.single_chip && core_ext_c
    |=> sys_reset_req ##1 s_reg.status[pat_pkg::PAT_ST_UNIMP] || $past(st_clr[pat_pkg::PAT_ST_UNIMP]))
    else $error("unimplemented access without reset");

  stop_freeze_a: assert property (
    stop_mode [*2] |-> !core_gvalid && !dbg_gvalid && !cop_gvalid && $stable(core_gaddr))
    else $error("translation active in stop");

  cop_map_a: assert property (
    cop_req && !stop_mode |=> cop_gaddr == {pat_pkg::PAT_COP_GP, $past(cop_addr)})
    else $error("coprocessor map wrong");

  apb_answer_a: assert property (
    setup && !s_reg.pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  prog_external_a: assert property (
    core_paged && core_addr >= pat_pkg::PAT_PROG_LO && core_addr <= pat_pkg::PAT_PROG_HI
    |=> core_external == ($past(s_reg.prog) < $past(s_reg.first_page)))
    else $error("program window target side wrong");

  dbg_local_a: assert property (
    dbg_req && !stop_mode && !dbg_hw_cmd && dbg_addr > pat_pkg::PAT_PROG_HI
    |=> dbg_gaddr == {pat_pkg::PAT_UNPAGED_GP, $past(dbg_addr)})
    else $error("debug page used outside its commands");

  expanded_no_reset_a: assert property (
    core_req && !stop_mode && !s_reg.single_chip |=> !sys_reset_req)
    else $error("reset raised outside single-chip mode");

  global_cov: cover property (core_req && core_global_instr && !stop_mode);
  hw_cmd_cov: cover property (dbg_req && dbg_hw_cmd && !stop_mode);
  reset_cov: cover property (sys_reset_req);
  stop_cov: cover property (stop_mode [*2]);
  irq_cov: cover property (irq ##1 access && paddr[7:0] == pat_pkg::PAT_OFF_STAT);
endmodule
`default_nettype wire

/* File: verification/pat_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// memory target model: accepts each translated core access and remembers it
module pat_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gvalid,
  input wire logic [22:0] gaddr,
  output int hits,
  output logic [22:0] last_addr
);
  // one target cycle per valid pulse, none while translation is frozen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits <= 0;
      last_addr <= 23'h000000;
    end else if (gvalid === 1'b1) begin
      hits <= hits + 1;
      last_addr <= gaddr;
    end
  end
endmodule
`default_nettype wire

/* File: verification/paged_address_translation_test.sv */
`timescale 1ns/1ps
`default_nettype none
module paged_address_translation_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, er, core_req = 0, core_global_instr = 0, core_gvalid, core_external;
  logic [15:0] core_addr = 0, dbg_addr = 0, cop_addr = 0;
  logic [22:0] core_gaddr, dbg_gaddr, cop_gaddr, last_c = 0, last_d = 0, last_p = 0, tgt_addr;
  logic dbg_req = 0, dbg_hw_cmd = 0, dbg_fw_global = 0, dbg_gvalid, dbg_external, dbg_reg_wr = 0;
  logic [2:0] dbg_reg_sel = 0;
  logic [7:0] dbg_reg_wdata = 0, dbg_reg_rdata;
  logic cop_req = 0, cop_gvalid, sys_reset_req, irq;
  logic [31:0] seed = 32'h00013D6D;
  int num_errors = 0, comparisons = 0, cycles = 0, hits, nx = 0;
  int pp = 'hFE, rp = 'hFD, ep = 'hFE, cgp = 0, dgp = 0, sc = 1, fp = 'hF8;
  int offs[9] = '{'h00, 'h04, 'h08, 'h0C, 'h10, 'h14, 'h18, 'h1C, 'h20};
  int rst[9] = '{'hFE, 'hFD, 'hFE, 0, 0, 'hF801, 0, 0, 0};

  pat_mmc u_pat_mmc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .core_req(core_req), .core_addr(core_addr), .core_global_instr(core_global_instr),
    .core_gvalid(core_gvalid), .core_gaddr(core_gaddr), .core_external(core_external), .dbg_req(dbg_req),
    .dbg_addr(dbg_addr), .dbg_hw_cmd(dbg_hw_cmd), .dbg_fw_global(dbg_fw_global), .dbg_gvalid(dbg_gvalid),
    .dbg_gaddr(dbg_gaddr), .dbg_external(dbg_external), .dbg_reg_wr(dbg_reg_wr), .dbg_reg_sel(dbg_reg_sel),
    .dbg_reg_wdata(dbg_reg_wdata), .dbg_reg_rdata(dbg_reg_rdata), .cop_req(cop_req), .cop_addr(cop_addr),
    .cop_gvalid(cop_gvalid), .cop_gaddr(cop_gaddr), .sys_reset_req(sys_reset_req), .irq(irq));
  pat_partner u_pat_partner (.pclk(pclk), .presetn(presetn), .gvalid(core_gvalid), .gaddr(core_gaddr),
    .hits(hits), .last_addr(tgt_addr));

  initial begin
    forever #4 pclk = ~pclk;
  end
  // run ceiling
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // reference map of one local address
  function automatic int ref_map(int a, bit g, int gp);
    if (g) return gp * 65536 + a;
    if (a >= 'h8000 && a < 'hC000) return 'h400000 + pp * 16384 + a % 16384;
    if (a >= 'h1000 && a < 'h2000) return rp * 4096 + a % 4096;
    if (a >= 'h0800 && a < 'h0C00) return 'h100000 + ep * 1024 + a % 1024;
    if (a < 'h0800) return a;
    return 'h7F0000 + a;
  endfunction
  function automatic bit is_ext(int g);
    return (g / 'h400000) % 2 == 1 && (g / 16384) % 256 < fp;
  endfunction
  task automatic apb(input bit w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk(pready, 1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic dreg(input bit w, input logic [2:0] s, input logic [7:0] d, input int exp);
    @(posedge pclk);
    dbg_reg_wr <= w;
    dbg_reg_sel <= s;
    dbg_reg_wdata <= d;
    @(posedge pclk);
    dbg_reg_wr <= 0;
    @(posedge pclk);
    if (!w) chk(dbg_reg_rdata, exp);
  endtask
  // one access from core, debug unit and coprocessor in the same cycle
  task automatic xfer(input logic [15:0] ca, da, xa, input bit cg, fw, hw, stp);
    int ec, ed;
    ec = (cg && fw) ? dgp * 65536 + ca : ref_map(ca, cg, cgp);
    ed = hw ? dgp * 65536 + da : ref_map(da, 0, 0);
    @(posedge pclk);
    {core_req, dbg_req, cop_req, stop_mode} <= {3'b111, stp};
    {core_addr, dbg_addr, cop_addr} <= {ca, da, xa};
    {core_global_instr, dbg_fw_global, dbg_hw_cmd} <= {cg, fw, hw};
    @(posedge pclk);
    {core_req, dbg_req, cop_req} <= 3'h0;
    @(posedge pclk);
    stop_mode <= 0;
    if (!stp) begin
      last_c = ec;
      last_d = ed;
      last_p = 'h780000 + xa;
      nx = nx + 1;
    end
    chk({core_gvalid, dbg_gvalid, cop_gvalid}, stp ? 0 : 7);
    chk(core_gaddr, last_c);
    chk(dbg_gaddr, last_d);
    chk(cop_gaddr, last_p);
    if (!stp) chk({core_external, dbg_external}, {is_ext(ec), is_ext(ed)});
    chk(sys_reset_req, !stp && sc == 1 && is_ext(ec));
  endtask

  initial begin
    logic [31:0] r;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    // reset values and the unmapped offset
    for (int i = 0; i < 9; i++) begin
      apb(0, offs[i], 0);
      chk(rd, rst[i]);
      chk(er, i == 8);
    end
    // random pages and random accesses of every kind
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        r = rnd();
        pp = r[7:0];
        rp = r[15:8];
        ep = r[23:16];
        cgp = r[30:24];
        dgp = r[31:25] ^ r[6:0];
        foreach (offs[k]) if (k < 5) apb(1, offs[k], k < 3 ? r[8 * k +: 8] : (k == 3 ? cgp : dgp));
      end
      r = rnd();
      if (r[17:16] == 1) r[15:0] = {6'h02, r[9:0]};
      if (r[17:16] == 2) r[15:0] = {4'h1, r[11:0]};
      xfer(r[15:0], r[31:16] ^ r[15:0], r[23:8], r[20], r[21] & r[20], r[22], r[23] & r[24] & r[25]);
    end
    // debug unit writes the pages and both ports agree
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      dreg(1, s, r[7:0], 0);
      dreg(0, s, 0, s == 3 ? r[6:0] : r[7:0]);
      apb(0, s == 3 ? 'h10 : s * 4, 0);
      chk(rd, s == 3 ? r[6:0] : r[7:0]);
      case (s)
        0: pp = r[7:0];
        1: rp = r[7:0];
        2: ep = r[7:0];
        default: dgp = r[6:0];
      endcase
    end
    xfer(16'h9234, 16'h9234, 16'h0042, 0, 0, 0, 0);
    // unimplemented access raises the interrupt only while unmasked
    apb(1, 'h00, 'h10);
    pp = 'h10;
    apb(1, 'h1C, 1);
    apb(0, 'h18, 0);
    xfer(16'h8000, 16'h0000, 16'h0000, 0, 0, 0, 0);
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    apb(0, 'h18, 0);
    chk(rd[0], 1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(1, 'h1C, 0);
    xfer(16'hA000, 16'h0000, 16'h0000, 0, 0, 0, 0);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    // outside single-chip mode the same access is legal
    apb(1, 'h14, 'hF800);
    sc = 0;
    xfer(16'h8100, 16'h0800, 16'h0001, 0, 0, 0, 0);
    xfer(16'h1234, 16'h5678, 16'h9ABC, 1, 0, 0, 1);
    chk(hits, nx);
    chk(tgt_addr, last_c);
    complete_run();
  end
endmodule
`default_nettype wire
